/* sioc_defines.vh */
`ifndef SIOC_DEFINES_VH
`define SIOC_DEFINES_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SIOC_ADDR_CMD_LO      12'h000
`define SIOC_ADDR_CMD_HI      12'h004
`define SIOC_ADDR_RSP_LO      12'h008
`define SIOC_ADDR_RSP_HI      12'h00C
`define SIOC_ADDR_DRIVE       12'h010
`define SIOC_ADDR_CTRL        12'h014
`define SIOC_ADDR_RESP_DATA   12'h018
`define SIOC_ADDR_ALARM       12'h01C
// ----------------------------------------------------------------
// Command byte 0 fields
// ----------------------------------------------------------------
`define SIOC_C0_LAYOUT        7
`define SIOC_C0_ALARM_RESET_COMMAND         5
`define SIOC_C0_ESTOP_N       4
`define SIOC_C0_SERVO_ON_COMMAND          1
`define SIOC_C0_START         0
// ----------------------------------------------------------------
// Command byte 2 and 3 fields
// ----------------------------------------------------------------
`define SIOC_C2_HOME          7
`define SIOC_C2_POINT_TABLE_COMMAND          6
`define SIOC_C2_STN           5
`define SIOC_C2_STEP          4
`define SIOC_C2_JOG           3
`define SIOC_C2_HOLD          1
`define SIOC_C2_CANCEL        0
`define SIOC_C3_DIR           1
`define SIOC_C3_INC           0
// ----------------------------------------------------------------
// Command codes and response types
// ----------------------------------------------------------------
`define SIOC_CC_NOP           4'h0
`define SIOC_CC_DIRECT        4'h1
`define SIOC_CC_INTFEED       4'h2
`define SIOC_CC_NOTCH         4'h3
`define SIOC_CC_MULTI         4'h4
`define SIOC_RT_CMDPOS        4'h0
`define SIOC_RT_PRESPOS       4'h1
`define SIOC_RT_DEV           4'h2
`define SIOC_RT_CMDSPD        4'h3
`define SIOC_RT_PRESSPD       4'h4
`define SIOC_RT_TORQUE        4'h5
`define SIOC_RT_STATION       4'hA
`define SIOC_RT_POINT         4'hB
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SIOC_CMD_RESET        32'h0000_0010
`define SIOC_INIT_CYCLES      16'h0010
`endif

/* sioc_drive_model.sv */
`timescale 1ns/100ps
// Drive stand-in: servo follows its request, a move runs MOVE_LEN cycles
module sioc_drive_model #(parameter MOVE_LEN = 20) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Requests from the block
    input  wire        servoOnRequest,
    input  wire        moveStart,
    input  wire        moveCancel,
    input  wire        moveHold,
    // State back to the block
    output reg         servoEnergized,
    output wire        axisMoving,
    output reg  [31:0] presStation
);
    reg [7:0] leftQ;
    // Hold freezes travel so the move stays pending; cancel drops what is left
    always @(posedge clk) begin
        if (!nrst) begin
            servoEnergized <= 1'b0;
            leftQ          <= 8'h00;
            presStation    <= 32'h0000_0000;
        end else begin
            servoEnergized <= servoOnRequest;
            if (moveCancel)
                leftQ <= 8'h00;
            else if (moveStart)
                leftQ <= 8'(MOVE_LEN);
            else if (leftQ != 8'h00 && !moveHold) begin
                leftQ       <= leftQ - 8'h01;
                presStation <= presStation + 32'h0000_0001;
            end
        end
    end
    assign axisMoving = (leftQ != 8'h00);
endmodule // sioc_drive_model

/* sioc_servo_io.v */
// Behaviour
// R1 - Master supplies command code and data no later than raising command start.
// R2 - A command starts only on a zero-to-one edge of command start.
// R3 - Response byte 0 packs echo, ready, power, estop, alarm, warning, servo, ack.
// R4 - Layout echo copies the layout select bit of the command.
// R5 - Ready is low after reset and during unit initialisation, then high.
// R6 - Power status follows main power; without power commands are refused.
// R7 - Estop status is high while the active-low estop command is zero.
// R8 - Alarm status sets on any alarm; clears only after alarm reset.
// R9 - Warning status sets on any warning; clears after alarm reset.
// R10 - With a warning, commands run except data setting and the faulting command.
// R11 - Servo status is high only with servo command and servo energised.
// R12 - Servo drops on command off, estop, unit reset or alarm.
// R13 - Start acknowledge mirrors the received command start bit.
// R14 - Command byte 0 and byte 1 carry the general bits, type and code.
// R15 - Command bytes 2 and 3 carry move bits, hold, cancel, direction, relative.
// R16 - Command codes 0 to 4 decode to nop, direct, feed, notch, multi-speed.
// R17 - Response bytes 4 to 7 are selected by the response type.
// R18 - Station type gives present station stopped, start station while moving.
// R19 - Cancel stops the move, decelerates and drops remaining travel.
// R20 - Hold decelerates and keeps the move pending until released.
// R21 - Master selects block layout with command byte 0 bit 7.
// R22 - Estop is active low; its falling edge cancels motion and servo.
// R23 - Alarm reset clears alarms and warnings whose causes are gone.
// R24 - Unlisted response types return zero data.
// R25 - Command codes above 4 act as no operation, motion unaffected.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "sioc_defines.vh"
module sioc_servo_io (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Drive status inputs
    input  wire        mainPowerOn,
    input  wire        servoEnergized,
    input  wire        axisMoving,
    input  wire        alarmEvent,
    input  wire        warningEvent,
    input  wire        alarmCauseActive,
    input  wire        warningCauseActive,
    input  wire        dataSetCommand,
    input  wire        warnCausedCommand,
    input  wire [31:0] cmdPosition,
    input  wire [31:0] presPosition,
    input  wire [31:0] posDeviation,
    input  wire [31:0] cmdSpeed,
    input  wire [31:0] presSpeed,
    input  wire [31:0] torquePct,
    input  wire [31:0] presStation,
    input  wire [31:0] pointTableNum,
    // Drive control outputs
    output reg         servoOnRequest,
    output reg         moveStart,
    output reg  [3:0]  moveCode,
    output reg  [31:0] moveData,
    output reg         moveCancel,
    output reg         moveHold,
    output reg         moveDir,
    output reg         moveRelative
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [31:0] cmdLo_q;
    reg  [31:0] cmdHi_q;
    reg  [31:0] respData_q;
    reg  [31:0] startStation_q;
    reg  [15:0] initCnt_q;
    reg         ready_q;
    reg         alarm_q;
    reg         warning_q;
    reg         servoOn_q;
    reg         startPrev_q;
    reg         svonPrev_q;
    reg         estopPrev_q;
    reg         servoArmed_q;
    reg         unitReset_q;
    reg         moveActive_q;
    reg  [7:0]  rspByte0;
    reg  [7:0]  rspByte2;
    reg  [31:0] respData_d;

    // Byte fields of the command block
    wire [7:0]  cmdB0      = cmdLo_q[7:0];
    wire [7:0]  cmdB1      = cmdLo_q[15:8];
    wire [7:0]  cmdB2      = cmdLo_q[23:16];
    wire [7:0]  cmdB3      = cmdLo_q[31:24];
    wire [3:0]  cmdCode    = cmdB1[3:0];
    wire [3:0]  respType   = cmdB1[7:4];
    wire        layoutSel  = cmdB0[`SIOC_C0_LAYOUT];                  // [R21]
    wire        estopCmdN  = cmdB0[`SIOC_C0_ESTOP_N];
    wire        startBit   = cmdB0[`SIOC_C0_START];
    wire        svonCmd    = cmdB0[`SIOC_C0_SERVO_ON_COMMAND];
    wire        alarmRst   = cmdB0[`SIOC_C0_ALARM_RESET_COMMAND];
    wire        cancelBit  = cmdB2[`SIOC_C2_CANCEL];
    wire        holdBit    = cmdB2[`SIOC_C2_HOLD];

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire        apbWrite   = psel & penable & pwrite;
    wire        mapped     = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Decodes a known command code; unknown codes count as no operation
    function isMoveCode;
        input [3:0] code;
        begin
            isMoveCode = (code == `SIOC_CC_DIRECT) || (code == `SIOC_CC_INTFEED) ||
                         (code == `SIOC_CC_NOTCH)  || (code == `SIOC_CC_MULTI);   // [R16] [R25]
        end
    endfunction

    // Start edge seen this cycle with a move layout
    wire startEdge = startBit & ~startPrev_q & ~layoutSel;                    // [R2]
    // Refuse when unpowered, not ready, in estop, alarm, or a warning blocks it
    wire warnBlock = warning_q & (dataSetCommand | warnCausedCommand);        // [R10]
    wire cmdAllowed = mainPowerOn & ready_q & estopCmdN & ~alarm_q & ~warnBlock; // [R6]
    wire estopFall = estopPrev_q & ~estopCmdN;                                // [R22]

    // ----------------------------------------------------------------
    // Command block and control registers
    // ----------------------------------------------------------------
    // Command words written by the master; estop reset value is released
    always @(posedge clk) begin
        if (!nrst) begin
            cmdLo_q     <= `SIOC_CMD_RESET;
            cmdHi_q     <= 32'h0000_0000;
            unitReset_q <= 1'b0;
        end else begin
            unitReset_q <= 1'b0;
            if (apbWrite && paddr == `SIOC_ADDR_CMD_LO) begin
                cmdLo_q <= pwdata;                                            // [R1] [R14] [R15]
            end
            if (apbWrite && paddr == `SIOC_ADDR_CMD_HI) begin
                cmdHi_q <= pwdata;
            end
            if (apbWrite && paddr == `SIOC_ADDR_CTRL) begin
                unitReset_q <= pwdata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Ready and initialisation
    // ----------------------------------------------------------------
    // Counts down after reset or unit reset before accepting commands
    always @(posedge clk) begin
        if (!nrst) begin
            initCnt_q <= `SIOC_INIT_CYCLES;
            ready_q   <= 1'b0;
        end else if (unitReset_q) begin
            initCnt_q <= `SIOC_INIT_CYCLES;
            ready_q   <= 1'b0;                                                // [R5]
        end else if (initCnt_q != 16'h0000) begin
            initCnt_q <= initCnt_q - 16'h0001;
            ready_q   <= 1'b0;
        end else begin
            ready_q   <= 1'b1;                                                // [R5]
        end
    end

    // ----------------------------------------------------------------
    // Alarm and warning flags
    // ----------------------------------------------------------------
    // Set beats clear: an event in the reset cycle keeps the flag
    always @(posedge clk) begin
        if (!nrst) begin
            alarm_q   <= 1'b0;
            warning_q <= 1'b0;
        end else begin
            if (alarmEvent) begin
                alarm_q <= 1'b1;                                              // [R8]
            end else if (alarmRst && !alarmCauseActive) begin
                alarm_q <= 1'b0;                                              // [R23]
            end
            if (warningEvent) begin
                warning_q <= 1'b1;                                            // [R9]
            end else if (alarmRst && !warningCauseActive) begin
                warning_q <= 1'b0;                                            // [R23]
            end
        end
    end

    // ----------------------------------------------------------------
    // Servo on
    // ----------------------------------------------------------------
    // Arms on a rising servo command; any drop condition disarms until re-raised
    always @(posedge clk) begin
        if (!nrst) begin
            svonPrev_q     <= 1'b0;
            estopPrev_q    <= 1'b1;
            servoArmed_q   <= 1'b0;
            servoOnRequest <= 1'b0;
            servoOn_q      <= 1'b0;
        end else begin
            svonPrev_q  <= svonCmd;
            estopPrev_q <= estopCmdN;
            if (!svonCmd || !estopCmdN || unitReset_q || alarm_q || alarmEvent || !mainPowerOn) begin
                servoArmed_q <= 1'b0;                                         // [R12] [R22]
            end else if (svonCmd && !svonPrev_q && cmdAllowed) begin
                servoArmed_q <= 1'b1;                                         // [R6]
            end
            servoOnRequest <= servoArmed_q;
            servoOn_q      <= servoArmed_q & svonCmd & servoEnergized & estopCmdN & ~unitReset_q; // [R11]
        end
    end

    // ----------------------------------------------------------------
    // Move command execution
    // ----------------------------------------------------------------
    // Latches code and data at a start edge; cancel and estop abort
    always @(posedge clk) begin
        if (!nrst) begin
            startPrev_q    <= 1'b0;
            moveStart      <= 1'b0;
            moveCode       <= `SIOC_CC_NOP;
            moveData       <= 32'h0000_0000;
            moveCancel     <= 1'b0;
            moveHold       <= 1'b0;
            moveDir        <= 1'b0;
            moveRelative   <= 1'b0;
            moveActive_q   <= 1'b0;
            startStation_q <= 32'h0000_0000;
        end else begin
            startPrev_q <= startBit;
            moveStart   <= 1'b0;
            moveCancel  <= 1'b0;
            if (moveActive_q && (cancelBit || estopFall || !estopCmdN || unitReset_q)) begin
                moveCancel   <= 1'b1;                                         // [R19] [R22]
                moveActive_q <= 1'b0;
                moveHold     <= 1'b0;
            end else if (startEdge && cmdAllowed && isMoveCode(cmdCode) && !moveActive_q) begin
                moveStart      <= 1'b1;                                       // [R2] [R16]
                moveCode       <= cmdCode;
                moveData       <= cmdHi_q;
                moveDir        <= cmdB3[`SIOC_C3_DIR];
                moveRelative   <= cmdB3[`SIOC_C3_INC];
                moveActive_q   <= 1'b1;
                startStation_q <= presStation;                                // [R18]
            end else begin
                if (moveActive_q) begin
                    moveHold <= holdBit;                                      // [R20]
                end
                if (moveActive_q && !axisMoving && !holdBit && !moveStart) begin
                    moveActive_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Response data
    // ----------------------------------------------------------------
    // Selects response bytes 4 to 7 from the response type
    always @* begin
        case (respType)
            `SIOC_RT_CMDPOS:  respData_d = cmdPosition;                       // [R17]
            `SIOC_RT_PRESPOS: respData_d = presPosition;
            `SIOC_RT_DEV:     respData_d = posDeviation;
            `SIOC_RT_CMDSPD:  respData_d = cmdSpeed;
            `SIOC_RT_PRESSPD: respData_d = presSpeed;
            `SIOC_RT_TORQUE:  respData_d = torquePct;
            `SIOC_RT_STATION: respData_d = axisMoving ? startStation_q : presStation; // [R18]
            `SIOC_RT_POINT:   respData_d = pointTableNum;
            default:          respData_d = 32'h0000_0000;                     // [R24]
        endcase
    end

    // Registered so the response word is stable for a whole read
    always @(posedge clk) begin
        if (!nrst) begin
            respData_q <= 32'h0000_0000;
        end else begin
            respData_q <= respData_d;
        end
    end

    // General status and move status bytes
    always @* begin
        rspByte0 = {layoutSel,                                                // [R3] [R4]
                    ready_q,
                    mainPowerOn,                                              // [R6]
                    ~estopCmdN,                                               // [R7]
                    alarm_q,
                    warning_q,
                    servoOn_q,
                    startBit};                                                // [R13]
        rspByte2 = {cmdB2[7:3], 1'b0, moveHold, moveActive_q};
    end

    // ----------------------------------------------------------------
    // APB read mux
    // ----------------------------------------------------------------
    // Read data is registered; it is valid in the access cycle
    always @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SIOC_ADDR_CMD_LO:    prdata <= cmdLo_q;
                `SIOC_ADDR_CMD_HI:    prdata <= cmdHi_q;
                `SIOC_ADDR_RSP_LO:    prdata <= {cmdB3 & 8'h03, rspByte2, cmdB1, rspByte0};
                `SIOC_ADDR_RSP_HI:    prdata <= layoutSel ? 32'h0000_0000 : respData_q;
                `SIOC_ADDR_DRIVE:     prdata <= {30'h0000_0000, moveActive_q, servoOnRequest};
                `SIOC_ADDR_RESP_DATA: prdata <= respData_q;
                `SIOC_ADDR_ALARM:     prdata <= {30'h0000_0000, warning_q, alarm_q};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // sioc_servo_io

/* sioc_servo_io_asserts.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the servo command block
// ----------------------------------------
module sioc_servo_io_asserts (
    // Clock and reset
    input wire        clk,
    input wire        nrst,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // Drive side
    input wire        mainPowerOn,
    input wire        alarmEvent,
    input wire        servoOnRequest,
    input wire        moveStart,
    input wire [3:0]  moveCode,
    input wire        moveCancel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Completed writes; servo bounds leave room for the status lag of up to three cycles after a write
    wire wrAcc = psel && penable && pwrite;
    a_start_one_pulse: assert property (moveStart |=> !moveStart) else $error("move start held");
    a_code_in_range: assert property (moveStart |-> moveCode >= 4'h1 && moveCode <= 4'h4)
        else $error("move started with an unused code");
    a_start_needs_power: assert property (moveStart |-> $past(mainPowerOn)) else $error("move without power");
    a_servo_needs_power: assert property ($rose(servoOnRequest) |-> $past(mainPowerOn))
        else $error("servo armed without power");
    a_alarm_drops_servo: assert property (alarmEvent |-> ##[1:3] !servoOnRequest)
        else $error("servo kept through alarm");
    a_estop_drops_servo: assert property (wrAcc && paddr == 12'h000 && !pwdata[4] |-> ##[1:3] !servoOnRequest)
        else $error("servo kept through emergency stop");
    a_reset_drops_servo: assert property (wrAcc && paddr == 12'h014 && pwdata[0] |-> ##[1:3] !servoOnRequest)
        else $error("servo kept through unit reset");
    a_cancel_one_pulse: assert property (moveCancel |=> !moveCancel) else $error("cancel held");
    a_read_data_stands: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside a read");
endmodule // sioc_servo_io_asserts

bind sioc_servo_io sioc_servo_io_asserts chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .mainPowerOn(mainPowerOn), .alarmEvent(alarmEvent),
    .servoOnRequest(servoOnRequest), .moveStart(moveStart), .moveCode(moveCode), .moveCancel(moveCancel));

/* test_sioc_servo_io.sv */
`timescale 1ns/100ps
module test_sioc_servo_io;
    localparam MOVE_LEN = 20;
    reg          clk, nrst, psel, penable, pwrite;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata, d, st;
    reg          mainPowerOn, alarmEvent, warningEvent, alarmCause, warningCause;
    wire         pready, pslverr, servoOnRequest, moveStart, moveCancel, moveHold;
    wire         servoEnergized, axisMoving, moveDir, moveRelative;
    wire [31:0]  prdata, moveData, presStation;
    wire [3:0]   moveCode;
    reg  [31:0]  src [0:7];
    reg  [15:0]  seed;
    integer      i, k, err_count, check_count, cycles;
    logic [31:0] rdQ[$], mkQ[$];
    logic [35:0] mvQ[$];
    sioc_servo_io dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .mainPowerOn(mainPowerOn), .servoEnergized(servoEnergized), .axisMoving(axisMoving),
        .alarmEvent(alarmEvent), .warningEvent(warningEvent), .alarmCauseActive(alarmCause),
        .warningCauseActive(warningCause), .dataSetCommand(1'b0), .warnCausedCommand(1'b0),
        .cmdPosition(src[0]), .presPosition(src[1]), .posDeviation(src[2]), .cmdSpeed(src[3]),
        .presSpeed(src[4]), .torquePct(src[5]), .presStation(presStation), .pointTableNum(src[7]),
        .servoOnRequest(servoOnRequest), .moveStart(moveStart), .moveCode(moveCode), .moveData(moveData),
        .moveCancel(moveCancel), .moveHold(moveHold), .moveDir(moveDir), .moveRelative(moveRelative));
    sioc_drive_model #(.MOVE_LEN(MOVE_LEN)) drv (.clk(clk), .nrst(nrst), .servoOnRequest(servoOnRequest),
        .moveStart(moveStart), .moveCancel(moveCancel), .moveHold(moveHold),
        .servoEnergized(servoEnergized), .axisMoving(axisMoving), .presStation(presStation));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task rnd;
        seed = lfsr(seed);
        d[15:0] = seed;
        seed = lfsr(seed);
        d[31:16] = seed;
    endtask
    task bad(input string m);
        err_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task conclude;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer; held until pready is seen at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        rdQ.push_back(e); mkQ.push_back(m);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Watcher: every completed read and every move start takes the oldest note
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready) begin
            check_count++;
            if (rdQ.size() == 0) bad("unexpected read");
            else begin
                if ((prdata & mkQ[0]) !== (rdQ[0] & mkQ[0])) bad("read data");
                void'(rdQ.pop_front()); void'(mkQ.pop_front());
            end
        end
        if (nrst && moveStart !== 1'b0) begin
            check_count++;
            if (mvQ.size() == 0) bad("unexpected move start");
            else if ({moveCode, moveData} !== mvQ.pop_front()) bad("move code or data");
        end
    end
    // Hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad("timeout");
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
        mainPowerOn = 1'b1; alarmEvent = 1'b0; warningEvent = 1'b0; alarmCause = 1'b0; warningCause = 1'b0;
        err_count = 0; check_count = 0; cycles = 0; seed = 16'h003B; d = 32'h0000_0000;
        for (i = 0; i < 8; i++) begin rnd(); src[i] = d; end
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(12'h008, 32'h0000_0020, 32'h0000_00FF);
        rd(12'h000, 32'h0000_0010, 32'hFFFF_FFFF);
        repeat (20) @(posedge clk);
        rd(12'h008, 32'h0000_0060, 32'h0000_00FF);
        rd(12'h020, 32'h0000_0000, 32'hFFFF_FFFF);
        for (i = 0; i < 16; i++) begin
            apb(1'b1, 12'h000, {16'h0000, i[3:0], 4'h0, 8'h10});
            rd(12'h00C, (i < 6) ? src[i] : (i == 10) ? presStation : (i == 11) ? src[7] : 32'h0, ~32'h0);
        end
        apb(1'b1, 12'h000, 32'h0000_0012);
        repeat (4) @(posedge clk);
        rd(12'h008, 32'h0000_0062, 32'h0000_00FF);
        apb(1'b1, 12'h000, 32'h0000_0092);
        rd(12'h008, 32'h0000_0080, 32'h0000_0080);
        rd(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF);
        // Codes 1 to 15 started on a rising start bit; only 1 to 4 may move
        for (i = 1; i < 16; i++) begin
            rnd();
            st = presStation;
            apb(1'b1, 12'h004, d);
            if (i < 5) mvQ.push_back({i[3:0], d});
            apb(1'b1, 12'h000, {16'h0000, 4'hA, i[3:0], 8'h13});
            rd(12'h008, 32'h0000_0001, 32'h0000_0001);
            rd(12'h00C, st, 32'hFFFF_FFFF);
            while (axisMoving) @(posedge clk);
            apb(1'b1, 12'h000, {16'h0000, 4'hA, i[3:0], 8'h13});
            rd(12'h00C, presStation, 32'hFFFF_FFFF);
            apb(1'b1, 12'h000, 32'h0000_0012);
        end
        rnd();
        apb(1'b1, 12'h004, d);
        mvQ.push_back({4'h2, d});
        apb(1'b1, 12'h000, 32'h0000_0213);
        apb(1'b1, 12'h000, 32'h0002_0213);
        repeat (30) @(posedge clk);
        rd(12'h010, 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, 12'h000, 32'h0001_0213);
        repeat (3) @(posedge clk);
        rd(12'h010, 32'h0000_0000, 32'h0000_0002);
        apb(1'b1, 12'h000, 32'h0000_0002);
        rd(12'h008, 32'h0000_0010, 32'h0000_0012);
        apb(1'b1, 12'h000, 32'h0000_0012);
        rd(12'h008, 32'h0000_0000, 32'h0000_0012);
        apb(1'b1, 12'h000, 32'h0000_0010);
        apb(1'b1, 12'h000, 32'h0000_0012);
        // Alarm, then warning: sticky while the cause stays, cleared by reset after
        for (k = 0; k < 2; k++) begin
            alarmCause <= (k == 0); warningCause <= (k == 1); alarmEvent <= (k == 0); warningEvent <= (k == 1);
            @(posedge clk);
            alarmEvent <= 1'b0; warningEvent <= 1'b0;
            repeat (3) @(posedge clk);
            rd(12'h008, k ? 32'h0000_0006 : 32'h0000_0008, k ? 32'h0000_0006 : 32'h0000_000A);
            apb(1'b1, 12'h000, 32'h0000_0032);
            apb(1'b1, 12'h000, 32'h0000_0012);
            rd(12'h008, k ? 32'h0000_0004 : 32'h0000_0008, k ? 32'h0000_0004 : 32'h0000_0008);
            alarmCause <= 1'b0; warningCause <= 1'b0;
            apb(1'b1, 12'h000, 32'h0000_0032);
            apb(1'b1, 12'h000, 32'h0000_0012);
            rd(12'h008, 32'h0000_0000, k ? 32'h0000_0004 : 32'h0000_0008);
            apb(1'b1, 12'h000, 32'h0000_0010);
            apb(1'b1, 12'h000, 32'h0000_0012);
        end
        mainPowerOn <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0111);
        rd(12'h008, 32'h0000_0000, 32'h0000_0020);
        mainPowerOn <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0012);
        apb(1'b1, 12'h014, 32'h0000_0001);
        rd(12'h008, 32'h0000_0000, 32'h0000_0042);
        repeat (20) @(posedge clk);
        rd(12'h008, 32'h0000_0040, 32'h0000_0040);
        repeat (5) @(posedge clk);
        if (mvQ.size() != 0) bad("move start missing");
        conclude();
    end
endmodule // test_sioc_servo_io
